// file: logic/wdcg_pkg.sv
// Shared constants and types for the watchdog configuration guard
package wdcg_pkg;

    // Clock rates and derived divider for the watchdog oscillator
    localparam int unsigned CORE_CLK_HZ     = 100_000_000;
    localparam int unsigned WDOG_OSC_HZ     = 1_000_000;
    localparam int unsigned OSC_DIV_CYCLES  = CORE_CLK_HZ / WDOG_OSC_HZ;

    // Shortest time-out, in watchdog oscillator cycles (16K)
    localparam int unsigned BASE_OSC_CYCLES = 16384;
    localparam int unsigned PSEL_W          = 3;

    // Change window length in core clock cycles
    localparam int unsigned WINDOW_CYCLES   = 4;
    localparam int unsigned WCNT_W          = 3;
    localparam logic [WCNT_W-1:0] WINDOW_LOAD = WCNT_W'(WINDOW_CYCLES);
    localparam logic [WCNT_W-1:0] WINDOW_LAST = 3'h1;

    // APB register map, byte addresses
    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned CTRL_W       = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_OFFSET = 12'h004;
    localparam logic [CTRL_W-1:0] CTRL_RESET  = 8'h00;

    // Layout of watchdog_control_reg
    typedef struct packed {
        logic [2:0]        rsvd;
        logic              watchdog_change_unlock;
        logic              watchdog_enable_bit;
        logic [PSEL_W-1:0] timeout_prescale_select;
    } wdcg_ctrl_s;

    // Layout of the status register
    typedef struct packed {
        logic [5:0] rsvd;
        logic       fuse_captured;
        logic       safety_level2;
    } wdcg_stat_s;

    // Change window state, Gray coded
    typedef enum logic [1:0] {
        WIN_CLOSED = 2'b00,
        WIN_OPEN   = 2'b01
    } wdcg_win_e;

endpackage : wdcg_pkg

// file: logic/wdcg_timer.sv
// Watchdog period counter with prescaled oscillator tick
module wdcg_timer #(
    parameter int unsigned OSC_DIV  = wdcg_pkg::OSC_DIV_CYCLES,
    parameter int unsigned BASE_OSC = wdcg_pkg::BASE_OSC_CYCLES
) (
    // Clock and reset
    input  wire logic                        core_clk_i,
    input  wire logic                        resetn_i,
    // Control
    input  wire logic                        restart_i,
    input  wire logic                        run_i,
    input  wire logic [wdcg_pkg::PSEL_W-1:0] sel_i,
    // Expiry pulse
    output logic                             expire_o
);

    localparam int unsigned DIV_W = $clog2(OSC_DIV + 1);
    localparam int unsigned CNT_W = $clog2(BASE_OSC) + 9;

    // Refuse settings the counters cannot serve
    if (OSC_DIV < 1 || BASE_OSC < 1) begin : g_bad_param
        $error("wdcg_timer: OSC_DIV and BASE_OSC must be at least one");
    end

    logic [DIV_W-1:0] div_q;
    logic [CNT_W-1:0] osc_q;
    logic [CNT_W-1:0] period_m1;
    logic             tick;
    logic             clear;

    // Last count of the selected period, doubling per code step
    function automatic logic [CNT_W-1:0] last_count(
        input logic [wdcg_pkg::PSEL_W-1:0] sel);
        last_count = (CNT_W'(BASE_OSC) << sel) - CNT_W'(1);
    endfunction : last_count

    assign period_m1 = last_count(sel_i);
    assign tick      = (div_q == DIV_W'(OSC_DIV - 1));
    assign clear     = !run_i || restart_i;

    // Oscillator-rate tick derived from the core clock
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= '0;
        end else if (clear || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    // Period counter, restarted by restart, disable and reset
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_q <= '0;
        end else if (clear) begin
            osc_q <= '0;
        end else if (tick) begin
            if (osc_q >= period_m1) begin
                osc_q <= '0;
            end else begin
                osc_q <= osc_q + CNT_W'(1);
            end
        end
    end

    // One-cycle expiry when the period runs out unrestarted
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            expire_o <= 1'b0;
        end else begin
            expire_o <= !clear && tick && (osc_q >= period_m1);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    a_period_expiry: assert property (
        expire_o |-> $past(osc_q) >= $past(period_m1) && $past(tick))
        else $error("expiry without the selected period elapsing");

    a_restart_clears: assert property (
        clear |=> osc_q == '0 && !expire_o)
        else $error("restart or disable did not clear the counter");

endmodule : wdcg_timer

// file: logic/wdcg_top.sv
// Watchdog configuration guard with APB control register
// Function
// - Level 1: watchdog starts off; writing enable one turns it on freely.
// - Level 1: disabling or changing period only via the timed sequence.
// - Level 1: a write with unlock clear inside four cycles is applied.
// - Level 2: watchdog stays enabled; enable always reads one.
// - Level 2: period write inside four cycles applied; enable value ignored.
// - Hardware clears the change-unlock bit four cycles after it is set.
// - Fuse picks level: unprogrammed level 1 off, programmed level 2 on.
// - Prescale codes select 16K up to 2048K oscillator cycles, doubling.
// - Counter restarts on restart, disable, reset; expiry resets the device.
//
// The APB register port and the address map were chosen for this implementation.
module wdcg_top #(
    parameter int unsigned OSC_DIV  = wdcg_pkg::OSC_DIV_CYCLES,
    parameter int unsigned BASE_OSC = wdcg_pkg::BASE_OSC_CYCLES
) (
    // Clock and reset
    input  wire logic                              core_clk_i,
    input  wire logic                              resetn_i,
    // APB slave
    input  wire logic                              psel_i,
    input  wire logic                              penable_i,
    input  wire logic                              pwrite_i,
    input  wire logic [wdcg_pkg::ADDR_W-1:0]       paddr_i,
    input  wire logic [wdcg_pkg::DATA_W-1:0]       pwdata_i,
    output logic      [wdcg_pkg::DATA_W-1:0]       prdata_o,
    output logic                                   pready_o,
    output logic                                   pslverr_o,
    // Core side
    input  wire logic                              always_on_fuse_i,
    input  wire logic                              watchdog_restart_instr_i,
    // Watchdog state
    output logic                                   watchdog_enabled_o,
    output logic      [wdcg_pkg::PSEL_W-1:0]       timeout_prescale_select_o,
    output logic                                   wdt_reset_o
);

    // Configuration state
    logic                        fuse_taken_q;
    logic                        level2_q;
    logic                        en_q;
    logic [wdcg_pkg::PSEL_W-1:0] wdp_q;
    wdcg_pkg::wdcg_win_e         win_q;
    logic [wdcg_pkg::WCNT_W-1:0] win_cnt_q;

    // Bus state
    logic                        pready_q;
    logic                        pslverr_q;
    logic [wdcg_pkg::DATA_W-1:0] prdata_q;
    logic                        wdt_reset_q;

    // Decoded write
    wdcg_pkg::wdcg_ctrl_s        wd;
    logic                        setup;
    logic                        acc;
    logic                        wr_ctrl;
    logic                        open_req;
    logic                        change_ok;
    logic                        expire;

    // Register address decode, used by read, error and write paths
    function automatic logic is_ctrl(input logic [wdcg_pkg::ADDR_W-1:0] a);
        is_ctrl = (a == wdcg_pkg::CTRL_OFFSET);
    endfunction : is_ctrl

    function automatic logic is_stat(input logic [wdcg_pkg::ADDR_W-1:0] a);
        is_stat = (a == wdcg_pkg::STAT_OFFSET);
    endfunction : is_stat

    assign wd    = wdcg_pkg::wdcg_ctrl_s'(pwdata_i[wdcg_pkg::CTRL_W-1:0]);
    assign setup = psel_i && !penable_i;
    assign acc   = psel_i && penable_i && pready_q;
    assign wr_ctrl = acc && pwrite_i && is_ctrl(paddr_i);

    // Opening write needs unlock and enable in the same word
    assign open_req = wr_ctrl && wd.watchdog_change_unlock
                      && wd.watchdog_enable_bit;

    // Guarded change: unlock clear while the window is open
    assign change_ok = wr_ctrl && !wd.watchdog_change_unlock
                       && (win_q == wdcg_pkg::WIN_OPEN);

    // Fuse caught on the first edge after reset release, never in reset
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fuse_taken_q <= 1'b0;
            level2_q     <= 1'b0;
        end else if (!fuse_taken_q) begin
            fuse_taken_q <= 1'b1;
            level2_q     <= always_on_fuse_i;
        end
    end

    // Enable bit: free to set, cleared only by a guarded change
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_q <= wdcg_pkg::CTRL_RESET[3];
        end else if (!fuse_taken_q) begin
            en_q <= always_on_fuse_i;
        end else if (level2_q) begin
            en_q <= 1'b1;
        end else if (change_ok) begin
            en_q <= wd.watchdog_enable_bit;
        end else if (wr_ctrl && wd.watchdog_enable_bit) begin
            en_q <= 1'b1;
        end
    end

    // Prescale select moves only inside an open window
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wdp_q <= wdcg_pkg::CTRL_RESET[wdcg_pkg::PSEL_W-1:0];
        end else if (change_ok) begin
            wdp_q <= wd.timeout_prescale_select;
        end
    end

    // Change window: opened by the unlock write, closed after four
    // cycles or by the guarded write; reopening restarts the count
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            win_q     <= wdcg_pkg::WIN_CLOSED;
            win_cnt_q <= '0;
        end else if (open_req) begin
            win_q     <= wdcg_pkg::WIN_OPEN;
            win_cnt_q <= wdcg_pkg::WINDOW_LOAD;
        end else begin
            case (win_q)
                wdcg_pkg::WIN_OPEN: begin
                    if (change_ok || win_cnt_q == wdcg_pkg::WINDOW_LAST) begin
                        win_q     <= wdcg_pkg::WIN_CLOSED;
                        win_cnt_q <= '0;
                    end else begin
                        win_cnt_q <= win_cnt_q - 3'h1;
                    end
                end
                wdcg_pkg::WIN_CLOSED: begin
                    win_cnt_q <= '0;
                end
                default: begin
                    win_q     <= wdcg_pkg::WIN_CLOSED;
                    win_cnt_q <= '0;
                end
            endcase
        end
    end

    // Read view of the registers; enable reads one at level 2
    function automatic logic [wdcg_pkg::DATA_W-1:0] read_word(
        input logic [wdcg_pkg::ADDR_W-1:0] a);
        wdcg_pkg::wdcg_ctrl_s c;
        wdcg_pkg::wdcg_stat_s s;
        c = '0;
        s = '0;
        c.watchdog_change_unlock  = (win_q == wdcg_pkg::WIN_OPEN);
        c.watchdog_enable_bit     = en_q || level2_q;
        c.timeout_prescale_select = wdp_q;
        s.safety_level2           = level2_q;
        s.fuse_captured           = fuse_taken_q;
        if (is_ctrl(a)) begin
            read_word = wdcg_pkg::DATA_W'(c);
        end else if (is_stat(a)) begin
            read_word = wdcg_pkg::DATA_W'(s);
        end else begin
            read_word = '0;
        end
    endfunction : read_word

    // Control word as software would read it, watched by the level 2 check
    logic [wdcg_pkg::DATA_W-1:0] ctrl_word;
    wdcg_pkg::wdcg_ctrl_s        ctrl_view;

    always_comb begin
        ctrl_word = read_word(wdcg_pkg::CTRL_OFFSET);
        ctrl_view = wdcg_pkg::wdcg_ctrl_s'(ctrl_word[wdcg_pkg::CTRL_W-1:0]);
    end

    // APB answer: one wait-free access phase after each setup cycle.
    // Read data is caught at the setup edge so it stays stable.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !is_ctrl(paddr_i) && !is_stat(paddr_i);
        end
    end

    // Read data register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_q <= '0;
        end else if (setup) begin
            prdata_q <= pwrite_i ? '0 : read_word(paddr_i);
        end
    end

    // Period counter; disable and the restart instruction clear it
    wdcg_timer #(
        .OSC_DIV  (OSC_DIV),
        .BASE_OSC (BASE_OSC)
    ) u_timer (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .restart_i  (watchdog_restart_instr_i),
        .run_i      (en_q),
        .sel_i      (wdp_q),
        .expire_o   (expire)
    );

    // Device reset request, registered for a clean output
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wdt_reset_q <= 1'b0;
        end else begin
            wdt_reset_q <= expire;
        end
    end

    // Outputs straight from flops
    assign prdata_o                  = prdata_q;
    assign pready_o                  = pready_q;
    assign pslverr_o                 = pslverr_q;
    assign watchdog_enabled_o        = en_q;
    assign timeout_prescale_select_o = wdp_q;
    assign wdt_reset_o               = wdt_reset_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    a_fuse_initial: assert property (
        $rose(fuse_taken_q) |-> en_q == level2_q)
        else $error("initial enable does not follow the fuse");

    a_lvl1_free_on: assert property (
        fuse_taken_q && !level2_q && wr_ctrl && wd.watchdog_enable_bit
        |=> en_q)
        else $error("level 1 enable write did not enable");

    a_guarded_off: assert property (
        fuse_taken_q && en_q && !change_ok |=> en_q)
        else $error("enable cleared outside the change window");

    a_wdp_locked: assert property (
        !change_ok |=> $stable(wdp_q))
        else $error("prescale changed outside the change window");

    a_lvl1_apply: assert property (
        change_ok && !level2_q && fuse_taken_q
        |=> en_q == $past(wd.watchdog_enable_bit)
            && wdp_q == $past(wd.timeout_prescale_select))
        else $error("level 1 guarded write not applied");

    a_lvl2_apply: assert property (
        change_ok && level2_q
        |=> en_q && wdp_q == $past(wd.timeout_prescale_select))
        else $error("level 2 guarded write mishandled");

    a_lvl2_always_on: assert property (
        level2_q |-> en_q && ctrl_view.watchdog_enable_bit)
        else $error("level 2 watchdog not enabled");

    a_window_open: assert property (
        open_req ##1 (!wr_ctrl)[*3] |=> win_q == wdcg_pkg::WIN_OPEN)
        else $error("change window closed too early");

    a_window_close: assert property (
        open_req ##1 (!wr_ctrl)[*4] |=> win_q == wdcg_pkg::WIN_CLOSED)
        else $error("change window not closed after four cycles");

    c_lvl1_disable: cover property (
        open_req && !level2_q ##[1:4] change_ok ##1 !en_q);

    c_lvl2_period: cover property (
        open_req && level2_q ##[1:4] change_ok);

    c_expiry: cover property (wdt_reset_q);

    c_bad_addr: cover property (pslverr_q && acc);

endmodule : wdcg_top

// file: dv/test_watchdog_config_guard.sv
// Self-checking bench for the watchdog configuration guard
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end

module test_watchdog_config_guard;
    timeunit 1ns;
    timeprecision 1ps;

    // Short expiry counts keep the run brief
    localparam int DIV  = 2;
    localparam int BASE = 4;
    localparam logic [11:0] CTRL = wdcg_pkg::CTRL_OFFSET;
    localparam logic [11:0] STAT = wdcg_pkg::STAT_OFFSET;

    logic        core_clk_i = 1'b0;
    logic        resetn_i   = 1'b0;
    logic        psel_i     = 1'b0;
    logic        penable_i  = 1'b0;
    logic        pwrite_i   = 1'b0;
    logic [11:0] paddr_i    = 12'h000;
    logic [31:0] pwdata_i   = 32'h0000_0000;
    logic        fuse_i     = 1'b0;
    logic        restart_i  = 1'b0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        enabled_o;
    logic [2:0]  ps_o;
    logic        wdt_reset_o;
    // Reference model state and counters
    int          en_m, ps_m, lvl2_m, win_m, cyc, acc;
    int          fail_count, n_checks;

    wdcg_top #(.OSC_DIV(DIV), .BASE_OSC(BASE)) dut (
        .core_clk_i               (core_clk_i),
        .resetn_i                 (resetn_i),
        .psel_i                   (psel_i),
        .penable_i                (penable_i),
        .pwrite_i                 (pwrite_i),
        .paddr_i                  (paddr_i),
        .pwdata_i                 (pwdata_i),
        .prdata_o                 (prdata_o),
        .pready_o                 (pready_o),
        .pslverr_o                (pslverr_o),
        .always_on_fuse_i         (fuse_i),
        .watchdog_restart_instr_i (restart_i),
        .watchdog_enabled_o       (enabled_o),
        .timeout_prescale_select_o(ps_o),
        .wdt_reset_o              (wdt_reset_o)
    );

    // Clock and edge counter
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) cyc <= cyc + 1;

    // Verdict and end of run
    task test_done;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // Reset with a chosen fuse; model restarts from the fuse level
    task do_reset(input logic f);
        resetn_i <= 1'b0;
        fuse_i   <= f;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        en_m   = f;
        ps_m   = 0;
        lvl2_m = f;
        win_m  = -100;
    endtask : do_reset

    task idle(input int n);
        psel_i <= 1'b0;
        repeat (n) @(posedge core_clk_i);
    endtask : idle

    // One APB transfer; psel stays up so a setup may follow at once
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        int i;
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk_i);
            if (pready_o === 1'b1) break;
        end
        if (i == 50) begin
            fail_count++;
            test_done();
        end
        rd = prdata_o;
        err = pslverr_o;
        acc = cyc;
        penable_i <= 1'b0;
    endtask : apb

    // Control write with junk above bit 7, model update, optional check
    task wr(input logic [7:0] d, input int gap);
        logic [31:0] pw;
        logic [31:0] rd;
        logic        err;
        int          dt;
        pw = $urandom();
        pw[7:0] = d;
        apb(1'b1, CTRL, pw, rd, err);
        dt = acc - win_m;
        if (d[4] && d[3]) begin
            if (lvl2_m == 0) en_m = 1;
            win_m = acc;
        end else if (!d[4] && dt >= 1
                     && dt <= int'(wdcg_pkg::WINDOW_CYCLES)) begin
            if (lvl2_m == 0) en_m = d[3];
            ps_m = d[2:0];
            win_m = -100;
        end else if (!d[4] && d[3]) begin
            en_m = 1;
        end
        if (gap > 0) begin
            idle(gap);
            `CHK(enabled_o, en_m[0])
            `CHK(ps_o, ps_m[2:0])
        end
    endtask : wr

    function automatic logic [31:0] exp_ctrl();
        int o;
        o = acc - 2 - win_m;
        return {27'h0, (o >= 0 && o <= 3), en_m[0], ps_m[2:0]};
    endfunction : exp_ctrl

    // Wait for one expiry pulse under a bound
    task pulse_wait(output int t);
        int i;
        for (i = 0; i < 2000; i++) begin
            @(posedge core_clk_i);
            if (wdt_reset_o === 1'b1) break;
        end
        if (i == 2000) begin
            fail_count++;
            test_done();
        end
        t = cyc;
    endtask : pulse_wait

    // Guarded period change, then pulse spacing against the code
    task period(input int c);
        int t0, t1, dv;
        wr(8'h18, 0);
        wr({5'h01, c[2:0]}, 1);
        pulse_wait(t0);
        pulse_wait(t1);
        dv = t1 - t0 - ((BASE << c) * DIV);
        `CHK(dv >= -2 && dv <= 2, 1'b1)
    endtask : period

    // Run n cycles, restarting every so often, counting expiries
    task run(input int n, input int every, output int k);
        k = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_i);
            restart_i <= (every > 0 && i % every == 0);
            if (wdt_reset_o === 1'b1) k++;
        end
    endtask : run

    // Hang guard
    initial begin
        #900us;
        fail_count++;
        test_done();
    end

    initial begin
        logic [31:0] d;
        logic        e;
        int          k;
        void'($urandom(81202));
        do_reset(1'b0);
        `CHK(enabled_o, 1'b0)
        apb(1'b0, STAT, 32'h0, d, e);
        idle(1);
        `CHK(d, 32'h0000_0002)
        // Free enable, then unguarded changes are ignored
        wr(8'h08, 1);
        wr(8'h0d, 1);
        wr(8'h00, 1);
        // Opener then read shows the window; a write on its fourth cycle lands
        wr(8'h18, 0);
        apb(1'b0, CTRL, 32'h0, d, e);
        `CHK(d, exp_ctrl())
        wr(8'h05, 1);
        // Window runs out before the second write
        wr(8'h18, 4);
        wr(8'h06, 1);
        apb(1'b0, CTRL, 32'h0, d, e);
        idle(1);
        `CHK(d, exp_ctrl())
        // Unmapped address answers an error and changes nothing
        apb(1'b1, 12'h00c, 32'h0000_0018, d, e);
        `CHK(e, 1'b1)
        wr(8'h0f, 0);
        apb(1'b0, 12'h008, 32'h0, d, e);
        idle(1);
        `CHK({e, d}, 33'h1_0000_0000)
        // Every prescale code through the guarded sequence
        for (int c = 0; c < 8; c++) begin
            wr(8'h18, 0);
            wr({4'h0, 1'($urandom_range(0, 1)), 3'(c)}, 1);
        end
        for (int c = 0; c < 4; c++) period(c);
        run(200, 20, k);
        `CHK(k, 0)
        run(200, 0, k);
        `CHK(k >= 2, 1'b1)
        // Guarded disable stops expiries
        wr(8'h18, 0);
        wr(8'h00, 2);
        run(200, 0, k);
        `CHK(k, 0)
        // Second reset with the fuse programmed
        do_reset(1'b1);
        `CHK(enabled_o, 1'b1)
        apb(1'b0, STAT, 32'h0, d, e);
        `CHK(d, 32'h0000_0003)
        apb(1'b0, CTRL, 32'h0, d, e);
        idle(1);
        `CHK(d, exp_ctrl())
        wr(8'h00, 1);
        wr(8'h18, 0);
        wr(8'h02, 1);
        wr(8'h03, 1);
        wr(8'h10, 0);
        wr(8'h04, 1);
        period(1);
        // Fuse sampled again after a fresh reset
        do_reset(1'b0);
        `CHK(enabled_o, 1'b0)
        test_done();
    end
endmodule : test_watchdog_config_guard
